// ===== design/irqse_consts.svh
// offsets, field positions and reset values of the interrupt flag and mask registers
// Notes on behaviour
// R01 - alarm event sets flag A bit 4, sticky
// R02 - oscillator failure sets flag A bit 3, sticky
// R03 - port match sets flag A bit 0, sticky
// R04 - reading flags A returns then clears; reset zero
// R05 - flags A peek shows bits 4,3,0, no clear
// R06 - unused mask bits read ones, writes ignored
// R07 - host writes zero to mask A bit 5
// R08 - mask A bit 4 gates alarm requests
// R09 - mask A bit 3 gates osc fail; resets 0
// R10 - mask A bit 0 gates port match requests
// R11 - flag B bit 4 sets when initialization finishes
// R12 - timer B wrap sets bit 3
// R13 - timer A wrap sets bit 2; resets 1
// R14 - flags B clear on read; unused read zero
// R15 - flags B peek shows bits 4,3,2, no clear
// R16 - pin low while any enabled flag pending
// R17 - clock flags hold while low power status set
// R18 - event during clearing read keeps flag set
`ifndef IRQSE_CONSTS_SVH
`define IRQSE_CONSTS_SVH

// register offsets on the host register port
`define IRQSE_OFS_MASK_A 8'h30
`define IRQSE_OFS_FLAGS_A 8'h20
`define IRQSE_OFS_PEEK_A 8'h21
`define IRQSE_OFS_FLAGS_B 8'h22
`define IRQSE_OFS_PEEK_B 8'h23

// flag positions, group A
`define IRQSE_BIT_ALARM 4
`define IRQSE_BIT_OSC_FAIL 3
`define IRQSE_BIT_PORT_MATCH 0
// flag positions, group B
`define IRQSE_BIT_READY 4
`define IRQSE_BIT_TIMER_B 3
`define IRQSE_BIT_TIMER_A 2

// field layouts and reset values
`define IRQSE_FLAGS_A_USED 8'h19
`define IRQSE_FLAGS_A_CLOCK 8'h18
`define IRQSE_FLAGS_A_RST 8'h00
`define IRQSE_FLAGS_B_USED 8'h1C
`define IRQSE_FLAGS_B_RST 8'h04
`define IRQSE_MASK_A_RST 8'hF7
`define IRQSE_MASK_A_WR 8'h39
`define IRQSE_MASK_A_ONES 8'hC6

`endif

// ===== design/irqse_pkg.sv
// types shared by the interrupt flag and mask register block
package irqse_pkg;

   typedef logic [7:0] irqse_byte_t;

   // one-cycle event pulses from the surrounding sources
   typedef struct packed {
      logic clock_alarm;
      logic clock_osc_fail;
      logic port_match;
      logic ready_after_reset;
      logic timer_b_wrap;
      logic timer_a_wrap;
   } irqse_evt_s;

   // host register request, taken in one cycle
   typedef struct packed {
      logic rd;
      logic wr;
      irqse_byte_t addr;
      irqse_byte_t wdata;
   } irqse_req_s;

endpackage : irqse_pkg

// ===== design/irqse_flag_bank.sv
// bank of eight sticky flags with set-over-clear priority
`timescale 1ns/1ps
module irqse_flag_bank #(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire irqse_pkg::irqse_byte_t i_set,
   input wire irqse_pkg::irqse_byte_t i_clr,
   output irqse_pkg::irqse_byte_t o_flags
);

   irqse_pkg::irqse_byte_t flags_r;
   irqse_pkg::irqse_byte_t flags_nxt;

   // clear first, then set, so a colliding event survives
   always_comb begin
      flags_nxt = flags_r;
      if (i_ce) begin
         flags_nxt = (flags_r & ~i_clr) | i_set; // R18
      end
   end

   // storage only
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flags_r <= RST_VAL;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign o_flags = flags_r;

endmodule : irqse_flag_bank

// ===== design/irqse_regs.sv
// interrupt flag, peek and mask registers with the active-low interrupt pin
`timescale 1ns/1ps
`include "irqse_consts.svh"
module irqse_regs (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire irqse_pkg::irqse_req_s i_req,
   input wire irqse_pkg::irqse_evt_s i_evt,
   input wire irqse_pkg::irqse_byte_t i_mask_b,
   input wire logic i_low_power_event_status,
   output irqse_pkg::irqse_byte_t o_rdata,
   output logic o_rvalid,
   output logic o_int_n
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // place group A events at their flag positions
   function automatic irqse_pkg::irqse_byte_t pack_a(input irqse_pkg::irqse_evt_s ev);
      irqse_pkg::irqse_byte_t v;
      v = 8'h00;
      v[`IRQSE_BIT_ALARM] = ev.clock_alarm; // R01
      v[`IRQSE_BIT_OSC_FAIL] = ev.clock_osc_fail; // R02
      v[`IRQSE_BIT_PORT_MATCH] = ev.port_match; // R03
      return v;
   endfunction : pack_a

   // place group B events at their flag positions
   function automatic irqse_pkg::irqse_byte_t pack_b(input irqse_pkg::irqse_evt_s ev);
      irqse_pkg::irqse_byte_t v;
      v = 8'h00;
      v[`IRQSE_BIT_READY] = ev.ready_after_reset; // R11
      v[`IRQSE_BIT_TIMER_B] = ev.timer_b_wrap; // R12
      v[`IRQSE_BIT_TIMER_A] = ev.timer_a_wrap; // R13
      return v;
   endfunction : pack_b

   // address match for a taken access
   function automatic logic hit(input irqse_pkg::irqse_byte_t a, input irqse_pkg::irqse_byte_t o);
      return a == o;
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////////
   // request decode

   logic rd_take;
   logic wr_take;
   irqse_pkg::irqse_byte_t set_a;
   irqse_pkg::irqse_byte_t set_b;
   irqse_pkg::irqse_byte_t clr_a;
   irqse_pkg::irqse_byte_t clr_b;
   irqse_pkg::irqse_byte_t flags_a;
   irqse_pkg::irqse_byte_t flags_b;
   irqse_pkg::irqse_byte_t keep_a;

   // a frozen clock enable drops the request, nothing is half taken
   assign rd_take = i_ce & i_req.rd;
   assign wr_take = i_ce & i_req.wr;
   assign set_a = pack_a(i_evt);
   assign set_b = pack_b(i_evt);

   // clock flags stay latched while the low power status still holds them
   assign keep_a = i_low_power_event_status ? `IRQSE_FLAGS_A_CLOCK : 8'h00; // R17

   // a clearing read empties every used bit it returned, except the group A clock bits that keep_a holds
   assign clr_a = (rd_take && hit(i_req.addr, `IRQSE_OFS_FLAGS_A))
      ? (`IRQSE_FLAGS_A_USED & ~keep_a) : 8'h00; // R04
   assign clr_b = (rd_take && hit(i_req.addr, `IRQSE_OFS_FLAGS_B))
      ? `IRQSE_FLAGS_B_USED : 8'h00; // R14

   ////////////////////////////////////////////////////////////////////////////
   // sticky flag banks

   // group A: alarm, oscillator failure, port match
   irqse_flag_bank #(
      .RST_VAL(`IRQSE_FLAGS_A_RST)
   ) u_flags_a (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_set(set_a),
      .i_clr(clr_a),
      .o_flags(flags_a)
   );

   // group B: ready after reset, timer wraps; timer A wrap starts set
   irqse_flag_bank #(
      .RST_VAL(`IRQSE_FLAGS_B_RST)
   ) u_flags_b (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_set(set_b),
      .i_clr(clr_b),
      .o_flags(flags_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // mask register A

   irqse_pkg::irqse_byte_t mask_a_r;
   irqse_pkg::irqse_byte_t mask_a_nxt;

   // only the documented bits take writes; bit 5 is stored as written
   always_comb begin
      mask_a_nxt = mask_a_r;
      if (wr_take && hit(i_req.addr, `IRQSE_OFS_MASK_A)) begin
         mask_a_nxt = (mask_a_r & ~`IRQSE_MASK_A_WR)
            | (i_req.wdata & `IRQSE_MASK_A_WR); // R06
      end
   end

   // osc fail enable is the only zero in the reset value
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mask_a_r <= `IRQSE_MASK_A_RST; // R09
      end else begin
         mask_a_r <= mask_a_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data

   irqse_pkg::irqse_byte_t rd_mux;
   irqse_pkg::irqse_byte_t rdata_r;
   irqse_pkg::irqse_byte_t rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;

   // the read returns the flags as they were before its own clear
   always_comb begin
      case (i_req.addr)
         `IRQSE_OFS_FLAGS_A: rd_mux = flags_a & `IRQSE_FLAGS_A_USED; // R04
         `IRQSE_OFS_PEEK_A: rd_mux = flags_a & `IRQSE_FLAGS_A_USED; // R05
         `IRQSE_OFS_FLAGS_B: rd_mux = flags_b & `IRQSE_FLAGS_B_USED; // R14
         `IRQSE_OFS_PEEK_B: rd_mux = flags_b & `IRQSE_FLAGS_B_USED; // R15
         `IRQSE_OFS_MASK_A: rd_mux = mask_a_r | `IRQSE_MASK_A_ONES; // R06
         default: rd_mux = 8'h00;
      endcase
   end

   // data holds until the next taken read
   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = rvalid_r;
      if (i_ce) begin
         rvalid_nxt = rd_take;
         if (rd_take) begin
            rdata_nxt = rd_mux;
         end
      end
   end

   // registered answer
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt pin

   logic pend_any;
   logic int_n_r;
   logic int_n_nxt;

   // a masked flag still latches, it just does not pull the pin
   assign pend_any = |(flags_a & mask_a_r & `IRQSE_FLAGS_A_USED) // R08 R10
      | |(flags_b & i_mask_b & `IRQSE_FLAGS_B_USED);

   // pin follows the enabled pending set one cycle late
   always_comb begin
      int_n_nxt = int_n_r;
      if (i_ce) begin
         int_n_nxt = ~pend_any; // R16
      end
   end

   // pin stays released through reset
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         int_n_r <= 1'b1;
      end else begin
         int_n_r <= int_n_nxt;
      end
   end

   assign o_rdata = rdata_r;
   assign o_rvalid = rvalid_r;
   assign o_int_n = int_n_r;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   // all properties sample on the rising edge and rest through reset
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   // named taken reads keep the properties short
   logic rd_a;
   logic rd_b;
   logic rd_pa;
   logic rd_pb;
   logic rd_m;
   assign rd_a = rd_take && hit(i_req.addr, `IRQSE_OFS_FLAGS_A);
   assign rd_b = rd_take && hit(i_req.addr, `IRQSE_OFS_FLAGS_B);
   assign rd_pa = rd_take && hit(i_req.addr, `IRQSE_OFS_PEEK_A);
   assign rd_pb = rd_take && hit(i_req.addr, `IRQSE_OFS_PEEK_B);
   assign rd_m = rd_take && hit(i_req.addr, `IRQSE_OFS_MASK_A);

   // group A flags latch on their events and hold until a clearing read
   AST_ALARM_SET: assert property (i_ce && i_evt.clock_alarm |=> flags_a[4]) // R01
      else $error("alarm event did not set its flag");
   AST_OSC_SET: assert property (i_ce && i_evt.clock_osc_fail // R02
      |=> flags_a[3] ##1 (flags_a[3] || $past(rd_a)))
      else $error("osc fail flag did not set and hold");
   AST_PM_SET: assert property (i_ce && i_evt.port_match |=> flags_a[0]) // R03
      else $error("port match event did not set its flag");
   AST_PM_HOLD: assert property (flags_a[0] && !rd_a |=> flags_a[0]) // R03
      else $error("port match flag dropped without a clearing read");

   // clearing reads hand back the old flags, peeks leave them alone
   AST_READ_CLEARS: assert property (rd_a && !i_low_power_event_status && set_a == 8'h00 // R04
      |=> flags_a == 8'h00 && o_rvalid && o_rdata == $past(flags_a))
      else $error("clearing read of flags A misbehaved");
   AST_RVALID_DROP: assert property (i_ce && !rd_take |=> !o_rvalid) // R04
      else $error("read valid stood longer than one cycle");
   AST_RDATA_HOLD: assert property (!rd_take |=> $stable(o_rdata)) // R04
      else $error("read data moved without a taken read");
   AST_PEEK_A: assert property (rd_pa |=> o_rdata == $past(flags_a) // R05
      && (flags_a & $past(flags_a)) == $past(flags_a))
      else $error("peek of flags A changed or misreported flags");

   // mask A: only documented bits move, unused bits always read as ones
   AST_MASK_ONES: assert property (rd_m // R06
      |=> (o_rdata & `IRQSE_MASK_A_ONES) == `IRQSE_MASK_A_ONES)
      else $error("unused mask bits did not read as ones");
   AST_MASK_KEEP: assert property (wr_take && hit(i_req.addr, `IRQSE_OFS_MASK_A) // R06
      |=> (mask_a_r & `IRQSE_MASK_A_ONES) == ($past(mask_a_r) & `IRQSE_MASK_A_ONES))
      else $error("write moved an unused mask bit");
   AST_MASK_WRITE: assert property (wr_take && hit(i_req.addr, `IRQSE_OFS_MASK_A) // R08
      |=> mask_a_r[4] == $past(i_req.wdata[4]) && mask_a_r[7:6] == 2'b11)
      else $error("mask A write did not land correctly");

   // an enabled pending flag pulls the pin at the next edge
   AST_ALARM_PIN: assert property (i_ce && flags_a[4] && mask_a_r[4] |=> !o_int_n) // R08
      else $error("enabled alarm flag did not pull the pin");
   AST_OSC_PIN: assert property (i_ce && flags_a[3] && mask_a_r[3] |=> !o_int_n) // R09
      else $error("enabled osc fail flag did not pull the pin");
   AST_PM_PIN: assert property (i_ce && flags_a[0] && mask_a_r[0] |=> !o_int_n) // R10
      else $error("enabled port match flag did not pull the pin");
   AST_INT_PIN: assert property (i_ce |=> o_int_n == !$past(pend_any)) // R16
      else $error("interrupt pin does not follow enabled pending flags");

   // group B flags and their reads
   AST_READY_SET: assert property (i_ce && i_evt.ready_after_reset |=> flags_b[4]) // R11
      else $error("ready event did not set its flag");
   AST_TIMER_B_SET: assert property (i_ce && i_evt.timer_b_wrap |=> flags_b[3]) // R12
      else $error("timer B wrap did not set its flag");
   AST_TIMER_A_SET: assert property (i_ce && i_evt.timer_a_wrap |=> flags_b[2]) // R13
      else $error("timer A wrap did not set its flag");
   AST_B_CLEARS: assert property (rd_b && set_b == 8'h00 // R14
      |=> flags_b == 8'h00 && o_rdata == $past(flags_b))
      else $error("clearing read of flags B misbehaved");
   AST_B_UNUSED: assert property (rd_b || rd_pb // R14
      |=> (o_rdata & ~`IRQSE_FLAGS_B_USED) == 8'h00)
      else $error("unused flags B bits did not read as zero");
   AST_PEEK_B: assert property (rd_pb && !i_evt.ready_after_reset // R15
      |=> o_rdata[4] == $past(flags_b[4]) && flags_b[4] == $past(flags_b[4]))
      else $error("peek of flags B cleared or misreported ready flag");
   AST_PEEK_B_ALL: assert property (rd_pb && set_b == 8'h00 // R15
      |=> o_rdata == $past(flags_b) && flags_b == $past(flags_b))
      else $error("peek of flags B changed or misreported flags");

   // clock flags survive a clearing read while low power status holds them
   AST_LP_HOLD: assert property (rd_a && i_low_power_event_status && flags_a[4] // R17
      |=> flags_a[4])
      else $error("alarm flag cleared while low power status held it");
   AST_LP_OSC_HOLD: assert property (rd_a && i_low_power_event_status && flags_a[3] // R17
      |=> flags_a[3])
      else $error("osc fail flag cleared while low power status held it");
   AST_SET_WINS: assert property ((rd_a || rd_b) && (set_a | set_b) != 8'h00 // R18
      |=> (flags_a & $past(set_a)) == $past(set_a)
      && (flags_b & $past(set_b)) == $past(set_b))
      else $error("event colliding with clearing read was lost");

   // a low clock enable freezes flags and pin; pulses seen then are lost
   AST_FROZEN_FLAGS: assert property (!i_ce |=> $stable(flags_a) && $stable(flags_b)) // R03
      else $error("flags moved while the clock enable was low");
   AST_FROZEN_PIN: assert property (!i_ce |=> $stable(o_int_n) && $stable(o_rvalid)) // R16
      else $error("outputs moved while the clock enable was low");

   COV_READ_PENDING: cover property (rd_a && flags_a != 8'h00 ##1 flags_a == 8'h00);
   COV_PIN_LOW: cover property (o_int_n ##1 !o_int_n);
   COV_COLLIDE: cover property (rd_a && i_evt.port_match);
   COV_MASK_WR: cover property (wr_take && hit(i_req.addr, `IRQSE_OFS_MASK_A));
   COV_LP_HOLD: cover property (rd_a && i_low_power_event_status && flags_a != 8'h00);

endmodule : irqse_regs

// ===== tb/irqse_host.sv
// host model issuing register reads and writes toward the interrupt block
`timescale 1ns/1ps
module irqse_host (
   input wire logic i_clk,
   input wire irqse_pkg::irqse_byte_t i_rdata,
   input wire logic i_rvalid,
   output irqse_pkg::irqse_req_s o_req
);
   ////////////////////////////////////////
   // idle request at time zero
   initial begin
      o_req = '0;
   end

   // one-cycle write; address and data scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_req = '{1'b0, 1'b1, a, (a == 8'h30) ? (d & 8'hDF) : d};
      @(negedge i_clk);
      o_req = '{1'b0, 1'b0, ~a, ~d};
   endtask : wr

   // one-cycle read; data valid one edge after it is taken
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge i_clk);
      o_req = '{1'b1, 1'b0, a, 8'h00};
      @(negedge i_clk);
      o_req = '{1'b0, 1'b0, ~a, 8'hFF};
      q = i_rvalid ? i_rdata : 8'hXX;
   endtask : rd
endmodule : irqse_host

// ===== tb/irq_status_enable_regs_bench.sv
// self-checking bench for the interrupt flag and mask registers
`timescale 1ns/1ps
module irq_status_enable_regs_bench;
   logic clk, rst, ce, lp;
   irqse_pkg::irqse_evt_s evt;
   irqse_pkg::irqse_req_s req;
   irqse_pkg::irqse_byte_t rdata;
   irqse_pkg::irqse_byte_t mask_b;
   logic rvalid, int_n;
   int err_count, checked;
   logic [7:0] q;
   // expected flag bit for each event index, timer a first
   logic [7:0] bitv [6] = '{8'h04, 8'h08, 8'h10, 8'h01, 8'h08, 8'h10};

   ////////////////////////////////////////
   irqse_regs i_irqse_regs (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_req(req),
      .i_evt(evt), .i_mask_b(mask_b), .i_low_power_event_status(lp),
      .o_rdata(rdata), .o_rvalid(rvalid), .o_int_n(int_n));
   irqse_host i_irqse_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

   // free-running clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_irqse_host.rd(a, q);
      chk(q, exp);
   endtask : rd_chk

   // pin is registered one edge behind the flags, so let one edge pass
   task automatic pin_chk(input logic exp);
      @(negedge clk);
      chk({7'h00, int_n}, {7'h00, exp});
   endtask : pin_chk

   // one-cycle event pulse, bit n of the event struct
   task automatic pulse(input int n);
      @(negedge clk);
      evt = irqse_pkg::irqse_evt_s'(6'(1 << n));
      @(negedge clk);
      evt = '0;
   endtask : pulse

   task automatic t_reset();
      rd_chk(8'h21, 8'h00);
      rd_chk(8'h23, 8'h04);
      rd_chk(8'h30, 8'hF7);
      pin_chk(1'b0);
      rd_chk(8'h22, 8'h04);
      rd_chk(8'h23, 8'h00);
      pin_chk(1'b1);
   endtask : t_reset

   // every source: set, peek, clear, peek; osc fail masked by default
   task automatic t_events();
      logic [7:0] pk;
      for (int n = 0; n < 6; n++) begin
         pk = (n >= 3) ? 8'h21 : 8'h23;
         pulse(n);
         pin_chk(n == 4);
         rd_chk(pk, bitv[n]);
         rd_chk(pk - 8'h01, bitv[n]);
         rd_chk(pk, 8'h00);
         pin_chk(1'b1);
      end
   endtask : t_events

   task automatic t_mask();
      i_irqse_host.wr(8'h30, 8'h00);
      rd_chk(8'h30, 8'hC6);
      pulse(5);
      pin_chk(1'b1);
      i_irqse_host.wr(8'h30, 8'h10);
      pin_chk(1'b0);
      rd_chk(8'h20, 8'h10);
      i_irqse_host.wr(8'h30, 8'h01);
      pulse(3);
      pin_chk(1'b0);
      rd_chk(8'h20, 8'h01);
      i_irqse_host.wr(8'h30, 8'h08);
      pulse(4);
      pin_chk(1'b0);
      rd_chk(8'h20, 8'h08);
      i_irqse_host.wr(8'h30, 8'hFF);
      rd_chk(8'h30, 8'hDF);
   endtask : t_mask

   task automatic t_low_power();
      lp = 1'b1;
      pulse(5);
      pulse(4);
      rd_chk(8'h20, 8'h18);
      rd_chk(8'h21, 8'h18);
      lp = 1'b0;
      rd_chk(8'h20, 8'h18);
      rd_chk(8'h21, 8'h00);
   endtask : t_low_power

   // event lands on the clearing read's own edge
   task automatic t_race();
      logic [7:0] r;
      fork
         i_irqse_host.rd(8'h20, r);
         pulse(3);
      join
      chk(r, 8'h00);
      rd_chk(8'h21, 8'h01);
      rd_chk(8'h20, 8'h01);
   endtask : t_race

   // unmapped read, write to a peek register, event while frozen
   task automatic t_misc();
      rd_chk(8'h40, 8'h00);
      @(negedge clk);
      chk({7'h00, rvalid}, 8'h00);
      i_irqse_host.wr(8'h21, 8'hFF);
      rd_chk(8'h21, 8'h00);
      ce = 1'b0;
      pulse(3);
      ce = 1'b1;
      rd_chk(8'h21, 8'h00);
      // timer A flag latches but a cleared enable keeps the pin released
      mask_b = 8'h00;
      pulse(0);
      pin_chk(1'b1);
      rd_chk(8'h22, 8'h04);
      mask_b = 8'hFF;
   endtask : t_misc

   task automatic print_verdict();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////
   // main sequence; reset held three cycles
   initial begin
      err_count = 0;
      checked = 0;
      rst = 1'b1;
      ce = 1'b1;
      lp = 1'b0;
      evt = '0;
      mask_b = 8'hFF;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_events();
      t_mask();
      t_low_power();
      t_race();
      t_misc();
      print_verdict();
   end

   // watchdog at 3000 cycles, far beyond the roughly 140 cycles the tests take
   initial begin
      #(5 * 3000);
      err_count++;
      print_verdict();
   end
endmodule : irq_status_enable_regs_bench
